// file: core/sccbrg_pkg.sv
// Package: register map, field positions, reset values, timing constants
`default_nettype none
package sccbrg_pkg;
  // Register offsets on the plain register port
  localparam logic [1:0] ADDR_CLOCK_MODE = 2'h0;
  localparam logic [1:0] ADDR_DIV_LOW = 2'h1;
  localparam logic [1:0] ADDR_DIV_HIGH = 2'h2;
  localparam logic [1:0] ADDR_MISC = 2'h3;
  // Clock mode control field positions
  localparam int XTAL_BIT = 7;
  localparam int RXSEL_LSB = 5;
  localparam int TXSEL_LSB = 3;
  localparam int DIR_BIT = 2;
  localparam int OSRC_LSB = 0;
  // Misc control field positions
  localparam int GSRC_BIT = 1;
  localparam int GEN_BIT = 0;
  // Reset values
  localparam logic [7:0] CLOCK_MODE_RST = 8'h08;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] MISC_RST = 8'h00;
  // Clock source selector codes
  localparam logic [1:0] SRC_SHARED = 2'h0;
  localparam logic [1:0] SRC_BIDIR = 2'h1;
  localparam logic [1:0] SRC_RATE = 2'h2;
  localparam logic [1:0] SRC_RECOV = 2'h3;
  // Output source codes
  localparam logic [1:0] OUT_XTAL = 2'h0;
  localparam logic [1:0] OUT_TXCLK = 2'h1;
  localparam logic [1:0] OUT_RATE = 2'h2;
  localparam logic [1:0] OUT_RECOV = 2'h3;
  // Enable takes effect after this many counts
  localparam logic [1:0] ENABLE_DELAY = 2'h2;
  // Oscillator settle time (software side)
  localparam int XTAL_SETTLE_MS = 20;
  localparam int CLOCK_MHZ = 50;
  localparam int XTAL_SETTLE_CYC = XTAL_SETTLE_MS * CLOCK_MHZ * 1000;
endpackage
`default_nettype wire

// file: core/sccbrg_top.sv
// Clock selection, pin control and rate generator of one serial channel
//
// The address-and-strobe port and the register addresses were left to the implementer.
`default_nettype none
module sccbrg_top
  import sccbrg_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Shared clock pin and oscillator
  input wire logic shared_clock_pin,
  input wire logic xtal_osc_in,
  output logic xtal_amp_en,
  input wire logic sync_pin_in,
  output logic sync_internal,
  // Bidirectional clock pin
  input wire logic bidir_clk_in,
  output logic bidir_clk_out,
  output logic bidir_clk_oe_n,
  // Clock recovery inputs
  input wire logic recov_rx_clk,
  input wire logic recov_tx_clk,
  input wire logic fm_mode,
  // Selected clocks
  output logic rx_clk,
  output logic tx_clk,
  output logic rate_out
);
  import sccbrg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] clock_mode_control_r; // Clock mode control
  logic [7:0] rate_divisor_low_r; // Low reload byte
  logic [7:0] rate_divisor_high_r; // High reload byte
  logic [7:0] misc_control_register_r; // Source and enable bits
  logic gen_running_r; // Generator past its enable delay

  // Software writes; reset values give shared-pin rx, bidir tx
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      clock_mode_control_r <= CLOCK_MODE_RST;
      rate_divisor_low_r <= DIV_RST;
      rate_divisor_high_r <= DIV_RST;
      misc_control_register_r <= MISC_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CLOCK_MODE: clock_mode_control_r <= reg_wdata;
        ADDR_DIV_LOW: rate_divisor_low_r <= reg_wdata;
        ADDR_DIV_HIGH: rate_divisor_high_r <= reg_wdata;
        ADDR_MISC: misc_control_register_r <= reg_wdata;
      endcase
    end
  end

  // Decoded fields
  logic xtal_sel;
  logic [1:0] rx_sel;
  logic [1:0] tx_sel;
  logic dir_out;
  logic [1:0] out_src;
  logic gen_src_bus;
  logic gen_enable;
  assign xtal_sel = clock_mode_control_r[XTAL_BIT];
  assign rx_sel = clock_mode_control_r[RXSEL_LSB +: 2];
  assign tx_sel = clock_mode_control_r[TXSEL_LSB +: 2];
  assign dir_out = clock_mode_control_r[DIR_BIT];
  assign out_src = clock_mode_control_r[OSRC_LSB +: 2];
  assign gen_src_bus = misc_control_register_r[GSRC_BIT];
  assign gen_enable = misc_control_register_r[GEN_BIT];

  // Readback: clock mode shows state; status word shows generator
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CLOCK_MODE: reg_rdata <= clock_mode_control_r;
        ADDR_DIV_LOW: reg_rdata <= rate_divisor_low_r;
        ADDR_DIV_HIGH: reg_rdata <= rate_divisor_high_r;
        ADDR_MISC: reg_rdata <= {5'h00, gen_running_r, gen_src_bus,
                                 gen_enable};
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared pin / oscillator source
  logic shared_src;
  // Oscillator output replaces the logic input when selected
  assign shared_src = xtal_sel ? xtal_osc_in : shared_clock_pin;

  // Amplifier enable and forced sync
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      xtal_amp_en <= 1'b0;
      sync_internal <= 1'b0;
    end else begin
      xtal_amp_en <= xtal_sel;
      sync_internal <= xtal_sel ? 1'b0 : sync_pin_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate generator: sampled edges of its source clock drive the count
  logic gen_src_r;
  logic gen_tick;
  // Bus clock source counts every cycle; pin source counts rising edges
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      gen_src_r <= 1'b0;
    end else begin
      gen_src_r <= shared_src;
    end
  end
  assign gen_tick = gen_src_bus ? 1'b1 : (shared_src & ~gen_src_r);

  logic [15:0] count_r;
  logic [1:0] arm_r; // Counts before enable is seen
  logic reloading_r;
  logic rate_q_r;

  // Enable arming: two counts before running, drop at once
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      arm_r <= 2'h0;
      gen_running_r <= 1'b0;
    end else if (!gen_enable) begin
      arm_r <= 2'h0;
      gen_running_r <= 1'b0;
    end else if (gen_tick && !gen_running_r) begin
      if (arm_r == ENABLE_DELAY - 2'h1) begin
        gen_running_r <= 1'b1;
      end
      arm_r <= arm_r + 2'h1;
    end
  end

  // Down counter: N..0, one reload cycle, repeat
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count_r <= 16'h0000;
      reloading_r <= 1'b1;
    end else if (!gen_running_r) begin
      reloading_r <= 1'b1;
    end else if (gen_tick) begin
      if (reloading_r) begin
        // New divisor only picked up here
        count_r <= {rate_divisor_high_r, rate_divisor_low_r};
        reloading_r <= 1'b0;
      end else if (count_r == 16'h0000) begin
        reloading_r <= 1'b1;
      end else begin
        count_r <= count_r - 16'h0001;
      end
    end
  end

  // Output toggles at terminal count; divisor = f/(2*rate*factor)-2
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rate_q_r <= 1'b0;
    end else if (gen_running_r && gen_tick && !reloading_r &&
                 count_r == 16'h0000) begin
      rate_q_r <= ~rate_q_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock multiplexers
  logic pin_used;
  logic tx_recov;
  logic pin_drive;
  logic rx_nxt;
  logic tx_nxt;
  assign pin_used = (rx_sel == SRC_BIDIR) || (tx_sel == SRC_BIDIR);
  // Transmitter gets lagged recovery clock only in FM
  assign tx_recov = fm_mode ? recov_tx_clk : recov_rx_clk;

  // Receive and transmit source selection
  always_comb begin
    unique case (rx_sel)
      SRC_SHARED: rx_nxt = shared_src;
      SRC_BIDIR: rx_nxt = bidir_clk_in;
      SRC_RATE: rx_nxt = rate_q_r;
      SRC_RECOV: rx_nxt = recov_rx_clk;
    endcase
    unique case (tx_sel)
      SRC_SHARED: tx_nxt = shared_src;
      SRC_BIDIR: tx_nxt = bidir_clk_in;
      SRC_RATE: tx_nxt = rate_q_r;
      SRC_RECOV: tx_nxt = tx_recov;
    endcase
  end

  // Pin output source; oscillator off means steady high
  always_comb begin
    unique case (out_src)
      OUT_XTAL: pin_drive = xtal_sel ? xtal_osc_in : 1'b1;
      OUT_TXCLK: pin_drive = tx_nxt;
      OUT_RATE: pin_drive = rate_q_r;
      OUT_RECOV: pin_drive = recov_rx_clk;
    endcase
  end

  // Registered outputs; register stage costs one cycle of latency
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_clk <= 1'b0;
      tx_clk <= 1'b0;
      rate_out <= 1'b0;
      bidir_clk_out <= 1'b0;
      bidir_clk_oe_n <= 1'b1;
    end else begin
      rx_clk <= rx_nxt;
      tx_clk <= tx_nxt;
      rate_out <= rate_q_r;
      // Drive only when direction bit set and pin not a clock input
      bidir_clk_oe_n <= ~(dir_out & ~pin_used);
      bidir_clk_out <= (dir_out & ~pin_used) ? pin_drive : 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_sync_forced;
    @(posedge clock) disable iff (sys_rst)
      xtal_sel |=> (sync_internal == 1'b0);
  endproperty
  a_sync_forced: assert property (p_sync_forced)
    else $error("sync not forced low in oscillator mode");

  property p_pin_input_when_used;
    @(posedge clock) disable iff (sys_rst)
      pin_used |=> bidir_clk_oe_n;
  endproperty
  a_pin_input_when_used: assert property (p_pin_input_when_used)
    else $error("bidirectional pin driven while used as input");

  property p_pin_dir;
    @(posedge clock) disable iff (sys_rst)
      (dir_out && !pin_used) |=> !bidir_clk_oe_n;
  endproperty
  a_pin_dir: assert property (p_pin_dir)
    else $error("bidirectional pin not driven");

  property p_xtal_high;
    @(posedge clock) disable iff (sys_rst)
      (dir_out && !pin_used && out_src == OUT_XTAL && !xtal_sel)
        |=> bidir_clk_out;
  endproperty
  a_xtal_high: assert property (p_xtal_high)
    else $error("pin not high with oscillator off");

  property p_rx_mux;
    @(posedge clock) disable iff (sys_rst)
      (rx_sel == SRC_RATE) |=> (rx_clk == $past(rate_q_r));
  endproperty
  a_rx_mux: assert property (p_rx_mux)
    else $error("receive clock not from rate generator");

  property p_tx_mux;
    @(posedge clock) disable iff (sys_rst)
      (tx_sel == SRC_BIDIR) |=> (tx_clk == $past(bidir_clk_in));
  endproperty
  a_tx_mux: assert property (p_tx_mux)
    else $error("transmit clock not from bidirectional pin");

  property p_disable_now;
    @(posedge clock) disable iff (sys_rst)
      !gen_enable |=> !gen_running_r ##1 $stable(rate_q_r);
  endproperty
  a_disable_now: assert property (p_disable_now)
    else $error("generator kept running after disable");

  property p_toggle_terminal;
    @(posedge clock) disable iff (sys_rst)
      $changed(rate_q_r) |-> $past(count_r) == 16'h0000;
  endproperty
  a_toggle_terminal: assert property (p_toggle_terminal)
    else $error("output toggled away from terminal count");

  property p_reload;
    @(posedge clock) disable iff (sys_rst)
      (gen_running_r && gen_tick && reloading_r) |=>
        count_r == {$past(rate_divisor_high_r), $past(rate_divisor_low_r)};
  endproperty
  a_reload: assert property (p_reload)
    else $error("counter not reloaded with divisor");

  property p_amp_follows;
    @(posedge clock) disable iff (sys_rst)
      1'b1 |=> (xtal_amp_en == $past(xtal_sel));
  endproperty
  a_amp_follows: assert property (p_amp_follows)
    else $error("amplifier enable does not follow crystal select");

  property p_tx_recov_lag;
    @(posedge clock) disable iff (sys_rst)
      (tx_sel == SRC_RECOV) |=>
        (tx_clk == $past(fm_mode ? recov_tx_clk : recov_rx_clk));
  endproperty
  a_tx_recov_lag: assert property (p_tx_recov_lag)
    else $error("transmit recovery clock wrong for mode");

  property p_pin_recov;
    @(posedge clock) disable iff (sys_rst)
      (dir_out && !pin_used && out_src == OUT_RECOV) |=>
        (bidir_clk_out == $past(recov_rx_clk));
  endproperty
  a_pin_recov: assert property (p_pin_recov)
    else $error("echoed recovery clock is not the receiver's");

  property p_pin_quiet;
    @(posedge clock) disable iff (sys_rst)
      !dir_out |=> (bidir_clk_oe_n && !bidir_clk_out);
  endproperty
  a_pin_quiet: assert property (p_pin_quiet)
    else $error("pin drive active while direction is input");

  property p_rx_shared;
    @(posedge clock) disable iff (sys_rst)
      (rx_sel == SRC_SHARED) |=> (rx_clk == $past(shared_src));
  endproperty
  a_rx_shared: assert property (p_rx_shared)
    else $error("receive clock not from shared pin");

  property p_count_down;
    @(posedge clock) disable iff (sys_rst)
      (gen_running_r && gen_tick && !reloading_r && count_r != 16'h0000)
        |=> (count_r == $past(count_r) - 16'h0001);
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("counter did not step down by one");

  property p_arm_delay;
    @(posedge clock) disable iff (sys_rst)
      (gen_enable && !gen_running_r && arm_r == 2'h0) |=> !gen_running_r;
  endproperty
  a_arm_delay: assert property (p_arm_delay)
    else $error("generator started before two counts");

  property p_rate_out;
    @(posedge clock) disable iff (sys_rst)
      1'b1 |=> (rate_out == $past(rate_q_r));
  endproperty
  a_rate_out: assert property (p_rate_out)
    else $error("rate output does not follow toggle flip-flop");
endmodule
`default_nettype wire

// file: testbench/sccbrg_far_side.sv
// Far-side clock sources and resolution of the bidirectional clock pin
`default_nettype none
module sccbrg_far_side (
  // Bench clock
  input wire logic clock,
  // Device drive of the bidirectional pin
  input wire logic bidir_clk_out,
  input wire logic bidir_clk_oe_n,
  // Sources toward the device
  output logic shared_clock_pin,
  output logic xtal_osc_in,
  output logic sync_pin_in,
  output logic recov_rx_clk,
  output logic recov_tx_clk,
  output logic bidir_clk_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tick_r = 8'h00; // Free-running step count
  logic [7:0] lag_t; // Step count a quarter cell behind
  // Sources move on the falling edge so each is still across a sample
  always @(negedge clock) begin
    tick_r <= tick_r + 8'h01;
  end
  assign lag_t = tick_r - 8'h04;
  assign shared_clock_pin = tick_r[1];
  assign xtal_osc_in = tick_r[0];
  assign sync_pin_in = tick_r[4];
  // Recovery cell is 16 steps; transmit copy lags by 4 of them
  assign recov_rx_clk = tick_r[3];
  assign recov_tx_clk = lag_t[3];
  // Far equipment releases the pin while the device drives it
  assign bidir_clk_in = bidir_clk_oe_n ? tick_r[2] : bidir_clk_out;
endmodule
`default_nettype wire

// file: testbench/serial_channel_clock_select_brg_tb.sv
// Register-driven testbench of the channel clock selection block
`default_nettype none
module serial_channel_clock_select_brg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sccbrg_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic shared_clock_pin, xtal_osc_in, xtal_amp_en, sync_pin_in;
  logic sync_internal, bidir_clk_in, bidir_clk_out, bidir_clk_oe_n;
  logic recov_rx_clk, recov_tx_clk, rx_clk, tx_clk, rate_out;
  logic xtal_on = 1'b0; // Bench copy of the crystal select
  logic fm_on = 1'b1; // Drives the FM mode input
  int fails = 0, n_checks = 0;
  always #10 clock = ~clock;
  sccbrg_top u_dut (.clock(clock), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .shared_clock_pin(shared_clock_pin), .xtal_osc_in(xtal_osc_in),
    .xtal_amp_en(xtal_amp_en), .sync_pin_in(sync_pin_in),
    .sync_internal(sync_internal), .bidir_clk_in(bidir_clk_in),
    .bidir_clk_out(bidir_clk_out), .bidir_clk_oe_n(bidir_clk_oe_n),
    .recov_rx_clk(recov_rx_clk), .recov_tx_clk(recov_tx_clk),
    .fm_mode(fm_on), .rx_clk(rx_clk), .tx_clk(tx_clk),
    .rate_out(rate_out));
  sccbrg_far_side u_far (.clock(clock), .bidir_clk_out(bidir_clk_out),
    .bidir_clk_oe_n(bidir_clk_oe_n), .shared_clock_pin(shared_clock_pin),
    .xtal_osc_in(xtal_osc_in), .sync_pin_in(sync_pin_in),
    .recov_rx_clk(recov_rx_clk), .recov_tx_clk(recov_tx_clk),
    .bidir_clk_in(bidir_clk_in));
  //////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One-cycle write, then two edges so outputs reflect it
  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [1:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Track an output against its source: 0 rx, 1 tx, 2 pin, 3 sync
  task automatic follow(string nm, int w, logic [1:0] c);
    logic e;
    logic s;
    repeat (16) begin
      @(posedge clock);
      #1;
      case (c)
        SRC_SHARED: e = (w == 2) ? (xtal_on ? xtal_osc_in : 1'b1)
                                 : shared_clock_pin;
        SRC_BIDIR: e = (w == 2) ? shared_clock_pin : bidir_clk_in;
        SRC_RATE: e = rate_out;
        default: e = (w == 1 && fm_on) ? recov_tx_clk : recov_rx_clk;
      endcase
      if (w == 3) e = xtal_on ? 1'b0 : sync_pin_in;
      s = (w == 0) ? rx_clk : (w == 1) ? tx_clk :
          (w == 2) ? bidir_clk_out : sync_internal;
      chk(nm, {15'h0, s}, {15'h0, e});
    end
  endtask
  // Cycles from the last change to the next one, bounded
  task automatic half(output int n);
    logic v;
    @(posedge clock);
    #1 v = rate_out;
    n = 1; // The edge above already counts
    while (rate_out === v && n < 2000) begin
      @(posedge clock);
      #1 n++;
    end
    if (rate_out === v) begin
      fails++;
      $display("[FAIL] half timed out expected change seen none");
      wrap_up();
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] d;
    int n;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rd(ADDR_CLOCK_MODE, d);
    chk("clock_mode", d, 8'h08);
    chk("oe_n", bidir_clk_oe_n, 1);
    chk("xtal_amp_en", xtal_amp_en, 0);
    // Every receive and transmit select code, recovery in FM mode
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CLOCK_MODE, {1'b0, c[1:0], c[1:0], 3'h0});
      follow("rx_clk", 0, c[1:0]);
      follow("tx_clk", 1, c[1:0]);
    end
    // Outside FM the transmitter takes the receiver's recovery clock
    fm_on <= 1'b0;
    wr(ADDR_CLOCK_MODE, 8'h18);
    follow("tx_nofm", 1, SRC_RECOV);
    fm_on <= 1'b1;
    // Pin as output, every source; oscillator off drives high
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CLOCK_MODE, {5'h0, 1'b1, c[1:0]});
      chk("oe_n", bidir_clk_oe_n, 0);
      follow("pin_out", 2, c[1:0]);
    end
    wr(ADDR_CLOCK_MODE, 8'h25);
    chk("oe_n", bidir_clk_oe_n, 1);
    wr(ADDR_CLOCK_MODE, 8'h0D);
    chk("oe_n", bidir_clk_oe_n, 1);
    wr(ADDR_CLOCK_MODE, 8'h03);
    chk("oe_n", bidir_clk_oe_n, 1);
    follow("sync", 3, 2'h0);
    // Model oscillator is steady at once, so no settle wait here
    xtal_on = 1'b1;
    wr(ADDR_CLOCK_MODE, 8'h84);
    chk("xtal_amp_en", xtal_amp_en, 1);
    follow("pin_osc", 2, 2'h0);
    follow("sync", 3, 2'h0);
    xtal_on = 1'b0;
    wr(ADDR_CLOCK_MODE, 8'h08);
    // Divisor written with the generator stopped
    wr(ADDR_MISC, 8'h00);
    wr(ADDR_DIV_LOW, 8'h03);
    wr(ADDR_DIV_HIGH, 8'h00);
    wr(ADDR_MISC, 8'h03);
    half(n);
    half(n);
    chk("half_n3", n, 5);
    // Low byte changed on the fly lands at the following reload
    wr(ADDR_DIV_LOW, 8'h07);
    half(n);
    half(n);
    chk("half_n7", n, 9);
    wr(ADDR_MISC, 8'h00);
    wr(ADDR_DIV_LOW, 8'h00);
    wr(ADDR_DIV_HIGH, 8'h01);
    wr(ADDR_MISC, 8'h03);
    half(n);
    half(n);
    chk("half_n256", n, 258);
    rd(ADDR_DIV_HIGH, d);
    chk("div_high", d, 8'h01);
    rd(ADDR_MISC, d);
    chk("misc_running", d, 8'h07);
    // Stop: output can still change two edges after the write, then holds
    wr(ADDR_MISC, 8'h02);
    d[0] = rate_out;
    repeat (20) begin
      @(posedge clock);
      #1 chk("stopped", rate_out, d[0]);
    end
    // Pin source: one count per shared pin rise, one rise per 4 cycles
    wr(ADDR_DIV_LOW, 8'h03);
    wr(ADDR_DIV_HIGH, 8'h00);
    wr(ADDR_MISC, 8'h01);
    half(n);
    half(n);
    chk("half_pin", n, 20);
    wrap_up();
  end
endmodule
`default_nettype wire
